// ---- cfbs_pkg.sv ----
// package: constants and types of the fetch and branch sequencer
// ==========================================
package cfbs_pkg;
    // ==========================================
    // widths
    localparam int PC_W = 11;
    localparam int OP_W = 12;
    localparam int STK_D = 8;
    // ==========================================
    // register byte offsets and fields
    localparam logic [7:0] R_CTRL = 8'h00;
    localparam logic [7:0] R_PC = 8'h04;
    localparam logic [7:0] R_W = 8'h08;
    localparam logic [7:0] R_STATUS = 8'h0C;
    localparam logic [7:0] R_DPTR = 8'h10;
    localparam logic [7:0] R_RETIRED = 8'h14;
    localparam logic [7:0] R_RTC = 8'h18;
    localparam logic [7:0] R_STK = 8'h1C;
    localparam logic [7:0] R_MODE = 8'h20;
    localparam logic [7:0] R_PORT = 8'h24;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_TURBO = 1;
    localparam logic [1:0] PSEL_DIR = 2'h0;
    localparam logic [1:0] PSEL_LVL = 2'h1;
    localparam logic [1:0] PSEL_PULL = 2'h2;
    // ==========================================
    // file addresses and field positions
    localparam logic [7:0] F_INDIRECT = 8'h00;
    localparam logic [7:0] F_RTC = 8'h01;
    localparam logic [7:0] F_PCL = 8'h02;
    localparam logic [7:0] F_STATUS = 8'h03;
    localparam logic [7:0] F_DPTR = 8'h04;
    localparam int F_BANKED = 4;
    localparam int BANK_LO = 5;
    localparam int PAGE_LO = 5;
    localparam int PAGE_HI = 6;
    // ==========================================
    // reset values and divider
    localparam logic [PC_W-1:0] PC_RST = 11'h7FF;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] MODE_RST = 8'h0F;
    localparam logic [7:0] PORT_RST = 8'hFF;
    localparam logic [1:0] DIV_LAST = 2'h3;
    // ==========================================
    // opcode classes (op[11:8], jump op[11:9]) and misc codes (op[7:0], page op[7:2], bank op[7:3])
    localparam logic [3:0] C_MISC = 4'h0;
    localparam logic [3:0] C_MOVWF = 4'h1;
    localparam logic [3:0] C_MOVFW = 4'h2;
    localparam logic [3:0] C_DECREMENT_SKIP_ZERO = 4'h3;
    localparam logic [3:0] C_INCSZ = 4'h4;
    localparam logic [3:0] C_CLRB = 4'h5;
    localparam logic [3:0] C_SETB = 4'h6;
    localparam logic [3:0] C_SB = 4'h7;
    localparam logic [3:0] C_SNB = 4'h8;
    localparam logic [3:0] C_LITERAL_RETURN = 4'h9;
    localparam logic [2:0] C_JMP = 3'h5;
    localparam logic [3:0] C_MOVLW = 4'hC;
    localparam logic [3:0] C_CALL = 4'hD;
    localparam logic [7:0] M_RET = 8'h0C;
    localparam logic [7:0] M_PAGED_RETURN = 8'h0D;
    localparam logic [7:0] M_INTERRUPT_RETURN = 8'h0E;
    localparam logic [7:0] M_INTERRUPT_RETURN_TIMER_ADJUST = 8'h0F;
    localparam logic [5:0] M_PAGE = 6'h04;
    localparam logic [4:0] M_BANK = 5'h03;
    // ==========================================
    // types
    typedef enum logic [4:0] {
        K_NOP, K_MOVWF, K_MOVFW, K_DECREMENT_SKIP_ZERO, K_INCSZ, K_CLRB, K_SETB, K_SB, K_SNB,
        K_LITERAL_RETURN, K_JMP, K_MOVLW, K_CALL, K_RET, K_PAGED_RETURN, K_INTERRUPT_RETURN, K_INTERRUPT_RETURN_TIMER_ADJUST, K_PAGE, K_BANK
    } cfbs_kind_t;
    typedef struct packed {
        logic valid;
        logic [PC_W-1:0] pc;
        logic [OP_W-1:0] op;
    } cfbs_fetch_t;
    typedef struct packed {
        logic valid;
        cfbs_kind_t kind;
        logic [PC_W-1:0] pc;
        logic [OP_W-1:0] op;
    } cfbs_dec_t;
    typedef struct packed {
        logic valid;
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } cfbs_wb_t;
    typedef struct packed {
        cfbs_fetch_t fq;
        cfbs_dec_t dq;
        cfbs_wb_t wq;
        logic [PC_W-1:0] pc;
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] data_pointer;
        logic [7:0] rtc;
        logic [STK_D-1:0][PC_W-1:0] stk;
        logic skipPend;
        logic [1:0] div;
        logic run;
        logic fuseTurbo;
        logic [15:0] retired;
        logic waitReq;
        logic [31:0] rdata;
        logic [7:0] mode;
        logic [2:0][7:0] port;
    } cfbs_state_t;
    localparam cfbs_state_t STATE_RST = '{pc: PC_RST, status: STATUS_RST, fuseTurbo: 1'b1,
        waitReq: 1'b1, mode: MODE_RST, port: {3{PORT_RST}}, default: '0};
endpackage

// ---- cfbs_core.sv ----
// core: four-stage instruction sequencer with return stack and Avalon-MM registers
`timescale 1ns/1ns
module cfbs_core import cfbs_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // avalon-mm register slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // program memory, read combinationally
    output logic [PC_W-1:0] pmAddr,
    input wire logic [OP_W-1:0] pmData,
    // port configuration
    output logic [7:0] portDir,
    output logic [7:0] portLvl,
    output logic [7:0] portPull
);
    // ==========================================
    // state and working signals
    cfbs_state_t s_reg, s_next; // whole block state
    logic [7:0] dataMem [0:255]; // data space RAM
    logic ce; // instruction clock enable
    logic live; // executing instruction is real
    logic flush; // pc rewritten this cycle
    logic doPush; // call pushes
    logic doPop; // return pops
    logic skipTaken; // skip condition true
    logic ramWe; // write-back into RAM
    cfbs_kind_t kind; // executing kind
    logic [PC_W-1:0] target; // new fetch address
    logic [PC_W-1:0] retAddr; // address pushed by a call
    logic [7:0] fwdFsr; // pointer after older write-back
    logic [4:0] fwdFsrLow; // low pointer bits seen by execute
    logic [1:0] pageSel; // page bits after older write-back
    logic [4:0] f5; // file field
    logic [7:0] eaddr; // resolved data address
    logic [7:0] opnd; // operand value
    logic [7:0] res; // arithmetic result
    logic [7:0] bitMask; // selected bit
    logic [7:0] lit; // literal field

    // ==========================================
    // decode: raw word to instruction kind
    function automatic cfbs_kind_t decodeOp(input logic [OP_W-1:0] op);
        cfbs_kind_t k;
        k = K_NOP;
        if (op[11:9] == C_JMP) begin
            k = K_JMP;
        end else begin
            case (op[11:8])
                C_MISC: begin
                    // page and bank carry their value in the low bits
                    if (op[7:2] == M_PAGE) begin
                        k = K_PAGE;
                    end else if (op[7:3] == M_BANK) begin
                        k = K_BANK;
                    end else begin
                        case (op[7:0])
                            M_RET: k = K_RET;
                            M_PAGED_RETURN: k = K_PAGED_RETURN;
                            M_INTERRUPT_RETURN: k = K_INTERRUPT_RETURN;
                            M_INTERRUPT_RETURN_TIMER_ADJUST: k = K_INTERRUPT_RETURN_TIMER_ADJUST;
                            default: k = K_NOP;
                        endcase
                    end
                end
                C_MOVWF: k = K_MOVWF;
                C_MOVFW: k = K_MOVFW;
                C_DECREMENT_SKIP_ZERO: k = K_DECREMENT_SKIP_ZERO;
                C_INCSZ: k = K_INCSZ;
                C_CLRB: k = K_CLRB;
                C_SETB: k = K_SETB;
                C_SB: k = K_SB;
                C_SNB: k = K_SNB;
                C_LITERAL_RETURN: k = K_LITERAL_RETURN;
                C_MOVLW: k = K_MOVLW;
                C_CALL: k = K_CALL;
                default: k = K_NOP;
            endcase
        end
        return k;
    endfunction

    // ==========================================
    // next-state logic
    always_comb begin
        s_next = s_reg;
        flush = 1'b0;
        doPush = 1'b0;
        doPop = 1'b0;
        skipTaken = 1'b0;
        res = 8'h00;
        target = s_reg.pc;
        kind = s_reg.dq.kind;
        lit = s_reg.dq.op[7:0];
        retAddr = s_reg.dq.pc + 11'h001;
        bitMask = 8'h01 << s_reg.dq.op[7:5];
        ce = s_reg.run && (s_reg.fuseTurbo || s_reg.div == 2'h0);

        // instruction-rate divider; turbo runs every oscillator cycle
        if (s_reg.run && !s_reg.fuseTurbo) begin
            s_next.div = (s_reg.div == DIV_LAST) ? 2'h0 : s_reg.div + 2'h1;
        end else begin
            s_next.div = 2'h0;
        end

        // write-back stage: file writes of the oldest instruction
        if (ce && s_reg.wq.valid) begin
            s_next.retired = s_reg.retired + 16'h0001;
            if (s_reg.wq.wr) begin
                case (s_reg.wq.addr)
                    F_RTC: s_next.rtc = s_reg.wq.data;
                    F_STATUS: s_next.status = s_reg.wq.data;
                    F_DPTR: s_next.data_pointer = s_reg.wq.data;
                    // RAM has its own process; pc low byte is not writable
                    default: ;
                endcase
            end
        end

        // execute reads values after the older write-back, so no stall
        fwdFsr = s_next.data_pointer;
        fwdFsrLow = fwdFsr[4:0];
        pageSel = s_next.status[PAGE_HI:PAGE_LO];
        f5 = s_reg.dq.op[4:0];
        if (f5 == F_INDIRECT[4:0]) begin
            eaddr = fwdFsr;
        end else if (f5[F_BANKED]) begin
            eaddr = {fwdFsr[7:BANK_LO], f5};
        end else begin
            eaddr = {3'h0, f5};
        end

        // operand fetch, forwarding a pending RAM write
        case (eaddr)
            F_INDIRECT: opnd = 8'h00; // pointer at itself reads zero
            F_RTC: opnd = s_next.rtc;
            F_PCL: opnd = s_reg.dq.pc[7:0];
            F_STATUS: opnd = s_next.status;
            F_DPTR: opnd = fwdFsr;
            default: begin
                if (s_reg.wq.valid && s_reg.wq.wr && s_reg.wq.addr == eaddr) begin
                    opnd = s_reg.wq.data;
                end else begin
                    opnd = dataMem[eaddr];
                end
            end
        endcase

        // skipped slots spend a cycle and touch nothing
        live = ce && s_reg.dq.valid && !s_reg.skipPend;
        if (ce) begin
            s_next.wq = '0;
            if (s_reg.dq.valid && s_reg.skipPend) begin
                s_next.skipPend = (kind == K_PAGE) || (kind == K_BANK);
            end
        end

        // execute stage
        if (live) begin
            s_next.wq.valid = 1'b1;
            s_next.wq.addr = eaddr;
            case (kind)
                K_MOVWF: begin
                    s_next.wq.wr = 1'b1;
                    s_next.wq.data = s_reg.w;
                end
                K_MOVFW: s_next.w = opnd;
                K_MOVLW: s_next.w = lit;
                K_DECREMENT_SKIP_ZERO, K_INCSZ: begin
                    res = (kind == K_DECREMENT_SKIP_ZERO) ? opnd - 8'h01 : opnd + 8'h01;
                    s_next.wq.wr = 1'b1;
                    s_next.wq.data = res;
                    skipTaken = (res == 8'h00);
                end
                K_CLRB: begin
                    s_next.wq.wr = 1'b1;
                    s_next.wq.data = opnd & ~bitMask;
                end
                K_SETB: begin
                    s_next.wq.wr = 1'b1;
                    s_next.wq.data = opnd | bitMask;
                end
                K_SB: skipTaken = |(opnd & bitMask);
                K_SNB: skipTaken = ~|(opnd & bitMask);
                K_JMP: begin
                    flush = 1'b1;
                    target = {pageSel, s_reg.dq.op[8:0]};
                end
                K_CALL: begin
                    flush = 1'b1;
                    doPush = 1'b1;
                    target = {pageSel, 1'b0, lit};
                end
                K_RET, K_PAGED_RETURN, K_INTERRUPT_RETURN, K_INTERRUPT_RETURN_TIMER_ADJUST, K_LITERAL_RETURN: begin
                    flush = 1'b1;
                    doPop = 1'b1;
                    target = s_reg.stk[0];
                    if (kind == K_PAGED_RETURN) begin
                        s_next.status[PAGE_HI:PAGE_LO] = s_reg.stk[0][PC_W-1:PC_W-2];
                    end
                    if (kind == K_INTERRUPT_RETURN_TIMER_ADJUST) begin
                        s_next.rtc = s_next.rtc + s_reg.w;
                    end
                    if (kind == K_LITERAL_RETURN) begin
                        s_next.w = lit;
                    end
                end
                K_PAGE: s_next.status[PAGE_HI:PAGE_LO] = s_reg.dq.op[1:0];
                K_BANK: s_next.data_pointer = {s_reg.dq.op[2:0], fwdFsrLow};
                default: ;
            endcase
            s_next.skipPend = skipTaken;
        end

        // return stack, level 1 at index 0
        if (doPush) begin
            s_next.stk = {s_reg.stk[STK_D-2:0], retAddr};
        end
        if (doPop) begin
            s_next.stk = {s_reg.stk[STK_D-1], s_reg.stk[STK_D-1:1]};
        end

        // decode and fetch stages
        if (ce) begin
            s_next.dq.valid = s_reg.fq.valid;
            s_next.dq.kind = decodeOp(s_reg.fq.op);
            s_next.dq.pc = s_reg.fq.pc;
            s_next.dq.op = s_reg.fq.op;
            s_next.fq.valid = 1'b1;
            s_next.fq.pc = s_reg.pc;
            s_next.fq.op = pmData;
            s_next.pc = s_reg.pc + 11'h001;
            // younger words are dropped before they reach execute
            if (flush) begin
                s_next.pc = target;
                s_next.fq.valid = 1'b0;
                s_next.dq.valid = 1'b0;
            end
        end

        // bus slave: one wait cycle, then the answer for one cycle
        s_next.waitReq = !((avs_read || avs_write) && s_reg.waitReq);
        if (avs_read && s_reg.waitReq) begin
            case (avs_address)
                R_CTRL: s_next.rdata = {30'h0, s_reg.fuseTurbo, s_reg.run};
                R_PC: s_next.rdata = {21'h0, s_reg.pc};
                R_W: s_next.rdata = {24'h0, s_reg.w};
                R_STATUS: s_next.rdata = {24'h0, s_reg.status};
                R_DPTR: s_next.rdata = {24'h0, s_reg.data_pointer};
                R_RETIRED: s_next.rdata = {16'h0, s_reg.retired};
                R_RTC: s_next.rdata = {24'h0, s_reg.rtc};
                R_STK: s_next.rdata = {21'h0, s_reg.stk[0]};
                R_MODE: s_next.rdata = {24'h0, s_reg.mode};
                R_PORT: begin
                    if (s_reg.mode[1:0] <= PSEL_PULL) begin
                        s_next.rdata = {24'h0, s_reg.port[s_reg.mode[1:0]]};
                    end else begin
                        s_next.rdata = 32'h0;
                    end
                end
                default: s_next.rdata = 32'h0;
            endcase
        end
        // writes land on the edge that ends the wait, low lane only
        if (avs_write && !s_reg.waitReq && avs_byteenable[0]) begin
            case (avs_address)
                R_CTRL: begin
                    s_next.run = avs_writedata[CTRL_RUN];
                    s_next.fuseTurbo = avs_writedata[CTRL_TURBO];
                end
                R_MODE: s_next.mode = avs_writedata[7:0];
                R_PORT: begin
                    // the mode value picks which port register is written
                    if (s_reg.mode[1:0] <= PSEL_PULL) begin
                        s_next.port[s_reg.mode[1:0]] = avs_writedata[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================
    // data RAM; special files never land here
    assign ramWe = ce && s_reg.wq.valid && s_reg.wq.wr && (s_reg.wq.addr > F_DPTR);
    always_ff @(posedge sys_clk) begin
        if (ramWe) begin
            dataMem[s_reg.wq.addr] <= s_reg.wq.data;
        end
    end

    // ==========================================
    // outputs, all straight from state
    assign pmAddr = s_reg.pc;
    assign avs_readdata = s_reg.rdata;
    assign avs_waitrequest = s_reg.waitReq;
    assign portDir = s_reg.port[PSEL_DIR];
    assign portLvl = s_reg.port[PSEL_LVL];
    assign portPull = s_reg.port[PSEL_PULL];

    // ==========================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_drained;
        !s_reg.fq.valid && !s_reg.dq.valid;
    endsequence
    sequence s_noResult;
        !s_reg.wq.valid;
    endsequence

    // in turbo the fetch address moves on every oscillator cycle unless a flush redirects it
    property p_turbo;
        s_reg.run && s_reg.fuseTurbo && !flush |=> s_reg.pc == $past(s_reg.pc) + 11'h001;
    endproperty
    a_turbo: assert property (p_turbo) else $error("turbo lost an instruction clock");

    property p_slow;
        ce && !s_reg.fuseTurbo |=> (!ce || s_reg.fuseTurbo) [*3];
    endproperty
    a_slow: assert property (p_slow) else $error("divide by four broken");

    property p_flush;
        ce && flush && s_reg.fuseTurbo && s_reg.run |=> s_drained ##1 s_noResult;
    endproperty
    a_flush: assert property (p_flush) else $error("flushed word survived");

    property p_push;
        ce && doPush |=> s_reg.stk[0] == $past(retAddr) && s_reg.stk[7] == $past(s_reg.stk[6]);
    endproperty
    a_push: assert property (p_push) else $error("push order wrong");

    property p_pop;
        ce && doPop |=> s_reg.pc == $past(s_reg.stk[0]) && s_reg.stk[6] == $past(s_reg.stk[7])
            && s_reg.stk[7] == $past(s_reg.stk[7]);
    endproperty
    a_pop: assert property (p_pop) else $error("pop order wrong");

    property p_jmp;
        live && kind == K_JMP |=> s_reg.pc[8:0] == $past(s_reg.dq.op[8:0])
            && s_reg.pc[10:9] == $past(pageSel);
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump target wrong");

    property p_call;
        live && kind == K_CALL |=> s_reg.pc[7:0] == $past(lit) && !s_reg.pc[8]
            && s_reg.pc[10:9] == $past(pageSel);
    endproperty
    a_call: assert property (p_call) else $error("call target wrong");

    property p_bank;
        live && kind == K_BANK |=> s_reg.data_pointer[4:0] == $past(fwdFsrLow);
    endproperty
    a_bank: assert property (p_bank) else $error("bank touched low bits");

    property p_skip;
        ce && s_reg.dq.valid && s_reg.skipPend |=> s_noResult;
    endproperty
    a_skip: assert property (p_skip) else $error("skipped word executed");

    property p_literal_return;
        live && kind == K_LITERAL_RETURN |=> s_reg.w == $past(lit);
    endproperty
    a_literal_return: assert property (p_literal_return) else $error("literal return lost value");

    property p_retire;
        ce && s_reg.wq.valid |=> s_reg.retired == $past(s_reg.retired) + 16'h0001;
    endproperty
    a_retire: assert property (p_retire) else $error("retire count off");

endmodule // cfbs_core

// ---- cfbs_prog_mem.sv ----
// partner model: combinational program memory holding the test program
`timescale 1ns/1ns
module cfbs_prog_mem import cfbs_pkg::*; (
    // fetch side
    input wire logic [PC_W-1:0] pmAddr,
    output logic [OP_W-1:0] pmData
);
    // ==========================================
    // storage and program image
    logic [OP_W-1:0] mem [2**PC_W]; // unused words hold nop
    // the image places two read-modify-writes on one file back to back, at 027 and 028
    // from 027: bit set, clear and both skips on the pointed byte, then four nested calls
    // unwound by interrupt, plain, timer-adjust and paged returns, ending in a loop at 02F
    localparam logic [22:0] PROG [35] = '{
        {11'h7FF, 12'hA00}, {11'h000, 12'h000}, {11'h001, 12'h011}, {11'h002, 12'h01B},
        {11'h003, 12'hD10}, {11'h004, 12'h010}, {11'h005, 12'hA20}, {11'h006, 12'hC77},
        {11'h210, 12'h9AA}, {11'h211, 12'hC55}, {11'h020, 12'h100}, {11'h021, 12'hC01},
        {11'h022, 12'h110}, {11'h023, 12'h200}, {11'h024, 12'h310}, {11'h025, 12'h013},
        {11'h026, 12'hC99}, {11'h027, 12'h600}, {11'h028, 12'h5E0}, {11'h029, 12'h700},
        {11'h02A, 12'hC11}, {11'h02B, 12'h8E0}, {11'h02C, 12'hC22}, {11'h02D, 12'h200},
        {11'h02E, 12'hD40}, {11'h02F, 12'hA2F}, {11'h040, 12'hD50}, {11'h041, 12'h012},
        {11'h042, 12'h00D}, {11'h050, 12'hD60}, {11'h051, 12'h00F}, {11'h060, 12'hD70},
        {11'h061, 12'h00C}, {11'h070, 12'h410}, {11'h071, 12'h00E}};
    // load at time zero; the words at 006 and 211, after a jump and a return, are traps if ever executed
    initial begin
        for (int i = 0; i < 2**PC_W; i++) mem[i] = 12'h000;
        foreach (PROG[i]) mem[PROG[i][22:12]] = PROG[i][11:0];
    end
    // memory answers in the same cycle, as the core expects
    assign pmData = mem[pmAddr];
endmodule // cfbs_prog_mem

// ---- cpu_fetch_branch_sequencer_tb.sv ----
// testbench: register bus, divider and program-flow scenarios for the sequencer
`timescale 1ns/1ns
module cpu_fetch_branch_sequencer_tb import cfbs_pkg::*; ();
    // ==========================================
    // signals
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avsAddress = 8'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0] avsByteenable = 4'hF;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [PC_W-1:0] pmAddr;
    logic [OP_W-1:0] pmData;
    logic [7:0] portDir, portLvl, portPull;
    int errors = 0;
    int checks = 0;
    logic [31:0] rd;
    int n;
    // ==========================================
    // clock, design and memory
    always #50 sys_clk = ~sys_clk;
    cfbs_core dut_u (.sys_clk(sys_clk), .rst(rst), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .pmAddr(pmAddr),
        .pmData(pmData), .portDir(portDir), .portLvl(portLvl), .portPull(portPull));
    cfbs_prog_mem mem_u (.pmAddr(pmAddr), .pmData(pmData));
    // ==========================================
    // helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one bus cycle; the request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge sys_clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWritedata <= d;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avsWaitrequest !== 1'b0 && k < 50);
        if (k >= 50) errors++;
        q = avsReaddata; // read data stands at the edge that ends the wait
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    // cycles until the fetch address next moves
    task automatic gap(output int c);
        logic [PC_W-1:0] a;
        a = pmAddr;
        c = 0;
        do begin
            @(posedge sys_clk);
            #1;
            c++;
        end while (pmAddr === a && c < 20);
    endtask
    task automatic stop_test();
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic test_reset();
        logic [7:0] adr [6] = '{R_CTRL, R_PC, R_STATUS, R_DPTR, R_MODE, 8'h30};
        logic [31:0] exp [6] = '{32'h2, 32'h7FF, 32'h18, 32'h0, 32'h0F, 32'h0};
        foreach (adr[i]) begin
            bus(1'b0, adr[i], 32'h0, rd);
            check("reset register", rd, exp[i]);
        end
        check("port config", {portDir, portLvl, portPull}, 24'hFFFFFF);
    endtask
    // mode steers the port window; a write without byte lane 0 is dropped
    task automatic test_ports();
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, R_MODE, m, rd);
            bus(1'b0, R_PORT, 32'h0, rd);
            check("port window", rd, (m == 3) ? 32'h0 : 32'hFF);
        end
        avsByteenable <= 4'hE;
        bus(1'b1, R_MODE, 32'h5, rd);
        avsByteenable <= 4'hF;
        bus(1'b0, R_MODE, 32'h0, rd);
        check("mode lane", rd, 32'h3);
        bus(1'b1, 8'h34, 32'h5, rd);
        // threshold window written and read back; other port registers keep reset
        bus(1'b1, R_MODE, 32'h1, rd);
        bus(1'b1, R_PORT, 32'h5A, rd);
        bus(1'b0, R_PORT, 32'h0, rd);
        check("port write", {rd[7:0], portDir, portLvl, portPull}, 32'h5AFF5AFF);
    endtask
    // fetch spacing with the fuse cleared, then set
    task automatic test_divider();
        bus(1'b1, R_CTRL, 32'h1, rd);
        gap(n);
        gap(n);
        check("divide by four", n, 4);
        bus(1'b1, R_CTRL, 32'h3, rd);
        gap(n);
        gap(n);
        check("divide by one", n, 1);
    endtask
    // page, bank, call, literal return, jump, indirect access, skips, bit ops and every return
    task automatic test_program();
        repeat (300) @(posedge sys_clk);
        bus(1'b0, R_W, 32'h0, rd);
        check("working register", rd, 32'h2B);
        bus(1'b0, R_STATUS, 32'h0, rd);
        check("page bits", rd[6:5], 2'h0);
        bus(1'b0, R_RTC, 32'h0, rd);
        check("timer counter", rd, 32'h2B);
        bus(1'b0, R_DPTR, 32'h0, rd);
        check("pointer", rd, 32'h60);
        bus(1'b0, R_STK, 32'h0, rd);
        check("stack level one", rd, 32'h0);
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        test_ports();
        test_divider();
        test_program();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        stop_test();
    end
endmodule // cpu_fetch_branch_sequencer_tb
